// ### design/stc_pkg.sv
/*
 * stc_pkg: constants shared by the serial link self-test checker.
 * Assumes an 8-bit register port and a 35-bit recovered payload word.
 */
package stc_pkg;
    // register offsets
    localparam logic [7:0] STC_ADDR_LINK_DETECT = 8'h1C;
    localparam logic [7:0] STC_ADDR_FWD_ERR     = 8'h25;
    localparam logic [7:0] STC_ADDR_CFG         = 8'h40;
    localparam logic [7:0] STC_ADDR_BC_CRC      = 8'h41;
    localparam logic [7:0] STC_ADDR_TEST_CRC    = 8'h42;
    // field positions
    localparam int STC_LD_BIT        = 0;
    localparam int STC_CFG_TEST_BIT  = 0;
    localparam int STC_CFG_OSC_BIT   = 1;
    localparam int STC_CFG_CLR_BIT   = 2;
    // reset values
    localparam logic [7:0] STC_CFG_RESET = 8'h00;
    localparam logic [7:0] STC_CNT_RESET = 8'h00;
    // widths
    localparam int STC_PAYLOAD_W = 35;
    localparam int STC_CNT_W     = 8;
    // timing: power-down low time the controller must hold, and oscillator rate
    localparam int STC_PDB_MIN_US   = 2000;
    localparam int STC_OSC_MHZ      = 33;
    localparam int STC_CLK_MHZ      = 40;
    localparam int STC_PDB_MIN_CYC  = STC_PDB_MIN_US * STC_CLK_MHZ;
endpackage : stc_pkg

// ### design/stc_checker.sv
/*
 * stc_checker: deserializer-side at-speed self-test of a serial video link.
 * Holds the pin synchronisers, the config register and the read mux on the
 * system clock, and the payload check, result pin and error counters on the
 * link clock.
 * Assumes linkClk is the recovered pixel clock (or the internal oscillator
 * picked by oscSelect outside), and that payload, lock and back-channel
 * status inputs are already on linkClk.
 * Assumes the register port is driven on the system clock, one write pulse
 * per write, and that regAddr is held while read data is wanted.
 * Counters reach the system clock as gray words; a clear that jumps several
 * codes may show one passing value.
 */
`timescale 1ns/1ps
module stc_checker
    import stc_pkg::*;
(
    input  wire logic                           clock,
    input  wire logic                           rst,
    input  wire logic                           clockEnable,
    input  wire logic                           linkClk,
    input  wire logic                           selfTestEnablePin,
    input  wire logic                           selfTestClockSelectPin,
    input  wire logic                           powerDownBarPin,
    input  wire logic [stc_pkg::STC_PAYLOAD_W-1:0] linkPayload,
    input  wire logic                           linkFrameValid,
    input  wire logic                           linkLock,
    input  wire logic                           remoteInTest,
    input  wire logic                           bcLinkDetect,
    input  wire logic                           bcCrcError,
    input  wire logic [7:0]                     regAddr,
    input  wire logic                           regWrite,
    input  wire logic [7:0]                     regWdata,
    output logic [7:0]                          regRdata,
    output logic                                selfTestRequest,
    output logic                                oscSelect,
    output logic                                lockStatus,
    output logic                                passPin
);
    import stc_pkg::*;

    typedef logic [STC_CNT_W-1:0] stc_cnt_t;

    // binary to gray
    function automatic stc_cnt_t stc_to_gray(input stc_cnt_t b);
        stc_to_gray = b ^ (b >> 1);
    endfunction : stc_to_gray

    // gray to binary, top bit down
    function automatic stc_cnt_t stc_from_gray(input stc_cnt_t g);
        stc_cnt_t b;
        b = '0;
        b[STC_CNT_W - 1] = g[STC_CNT_W - 1];
        for (int i = STC_CNT_W - 2; i >= 0; i--) begin
            b[i] = g[i] ^ b[i + 1];
        end
        stc_from_gray = b;
    endfunction : stc_from_gray

    // saturating increment, never wraps to a low count
    function automatic stc_cnt_t stc_sat_inc(input stc_cnt_t c);
        if (c == '1) begin
            stc_sat_inc = c;
        end else begin
            stc_sat_inc = c + stc_cnt_t'(1);
        end
    endfunction : stc_sat_inc

    // system-clock state
    typedef struct packed {
        // pin synchronisers
        logic            enS1;
        logic            enS2;
        logic            selS1;
        logic            selS2;
        logic            pdbS1;
        logic            pdbS2;
        // link-domain levels brought over
        logic            lockS1;
        logic            lockS2;
        logic            ldS1;
        logic            ldS2;
        // counter words in gray code, three counters
        logic [2:0][7:0] grayS1;
        logic [2:0][7:0] grayS2;
        // config register and clear request
        logic            cfgTest;
        logic            cfgOsc;
        logic            clrToggle;
        // registered outputs
        logic            testReq;
        logic            oscSel;
        logic            lockOut;
        logic [7:0]      rdata;
    } stc_sys_s;

    // link-clock state
    typedef struct packed {
        // clock enable brought into the link domain
        logic            ceS1;
        logic            ceS2;
        // test request and clear request synchronisers
        logic            actS1;
        logic            actS2;
        logic            clrS1;
        logic            clrS2;
        logic            clrS3;
        // result pin state and remote test edge
        logic            checking;
        logic            passHeld;
        logic            errPulse;
        logic            remotePrev;
        // error counters and their gray copies
        stc_cnt_t        fwdCnt;
        stc_cnt_t        bcCnt;
        stc_cnt_t        tcCnt;
        logic [2:0][7:0] gray;
    } stc_link_s;

    localparam stc_sys_s SYS_RESET = '{
        cfgTest:   STC_CFG_RESET[STC_CFG_TEST_BIT],
        cfgOsc:    STC_CFG_RESET[STC_CFG_OSC_BIT],
        testReq:   1'b0,
        oscSel:    1'b0,
        lockOut:   1'b0,
        rdata:     8'h00,
        default:   '0
    };
    localparam stc_link_s LINK_RESET = '{
        checking:  1'b0,
        errPulse:  1'b0,
        passHeld:  1'b1,
        fwdCnt:    STC_CNT_RESET,
        bcCnt:     STC_CNT_RESET,
        tcCnt:     STC_CNT_RESET,
        default:   '0
    };

    // state of both domains; only synchroniser flops read
    // a signal of the other domain
    stc_sys_s  sys;
    stc_sys_s  next_sys;
    stc_link_s lnk;
    stc_link_s next_lnk;
    // falling-edge copy of the error pulse
    logic      errNeg;

    // system domain: pin synchronisers, config register, read mux
    always_comb begin
        stc_cnt_t fwdBin;
        stc_cnt_t bcBin;
        stc_cnt_t tcBin;
        next_sys = sys;

        // counter words back to binary for reading
        fwdBin = stc_from_gray(sys.grayS2[0]);
        bcBin  = stc_from_gray(sys.grayS2[1]);
        tcBin  = stc_from_gray(sys.grayS2[2]);

        // pins, two flops each before any logic
        next_sys.enS1   = selfTestEnablePin;
        next_sys.enS2   = sys.enS1;
        next_sys.selS1  = selfTestClockSelectPin;
        next_sys.selS2  = sys.selS1;
        next_sys.pdbS1  = powerDownBarPin;
        next_sys.pdbS2  = sys.pdbS1;

        // link lock and link detect, two flops each
        next_sys.lockS1 = linkLock;
        next_sys.lockS2 = sys.lockS1;
        next_sys.ldS1   = bcLinkDetect;
        next_sys.ldS2   = sys.ldS1;

        // gray counter words, two flops
        next_sys.grayS1 = lnk.gray;
        next_sys.grayS2 = sys.grayS1;

        // software writes to the config register
        if (regWrite && regAddr == STC_ADDR_CFG) begin
            next_sys.cfgTest = regWdata[STC_CFG_TEST_BIT];
            next_sys.cfgOsc  = regWdata[STC_CFG_OSC_BIT];
            if (regWdata[STC_CFG_CLR_BIT]) begin
                next_sys.clrToggle = ~sys.clrToggle;
            end
        end

        // power-down pin low puts control registers back to default
        if (!sys.pdbS2) begin
            next_sys.cfgTest = STC_CFG_RESET[STC_CFG_TEST_BIT];
            next_sys.cfgOsc  = STC_CFG_RESET[STC_CFG_OSC_BIT];
        end

        // request, oscillator choice and lock level
        next_sys.testReq = sys.pdbS2 && (sys.enS2 || sys.cfgTest);
        next_sys.oscSel  = sys.selS2 || sys.cfgOsc;
        next_sys.lockOut = sys.lockS2;

        // registered read data
        case (regAddr)
            STC_ADDR_LINK_DETECT: next_sys.rdata = {7'h00, sys.ldS2};
            STC_ADDR_FWD_ERR:     next_sys.rdata = fwdBin;
            STC_ADDR_CFG:         next_sys.rdata = {6'h00, sys.cfgOsc, sys.cfgTest};
            STC_ADDR_BC_CRC:      next_sys.rdata = bcBin;
            STC_ADDR_TEST_CRC:    next_sys.rdata = tcBin;
            default:              next_sys.rdata = 8'h00;
        endcase
    end

    // system domain register, frozen while clock enable is low;
    // clock enable is on this clock, so it needs no synchroniser here
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sys <= SYS_RESET;
        end else if (clockEnable) begin
            sys <= next_sys;
        end
    end

    // link domain: payload check, result pin, error counters
    always_comb begin
        logic startTest;
        logic frameErr;
        logic remoteRise;
        logic swClear;
        startTest  = 1'b0;
        frameErr   = 1'b0;
        remoteRise = 1'b0;
        swClear    = 1'b0;
        next_lnk = lnk;

        // clock enable, two flops into the link domain
        next_lnk.ceS1 = clockEnable;
        next_lnk.ceS2 = lnk.ceS1;

        // test request and clear toggle from the system domain
        next_lnk.actS1 = sys.testReq;
        next_lnk.actS2 = lnk.actS1;
        next_lnk.clrS1 = sys.clrToggle;
        next_lnk.clrS2 = lnk.clrS1;
        next_lnk.clrS3 = lnk.clrS2;

        // remote test edge and software clear strobe
        next_lnk.remotePrev = remoteInTest;
        swClear    = lnk.clrS2 ^ lnk.clrS3;
        remoteRise = remoteInTest && !lnk.remotePrev;
        next_lnk.errPulse = 1'b0;

        // checking needs both ends in test and lock
        startTest = lnk.actS2 && remoteInTest && linkLock && !lnk.checking;
        if (!lnk.actS2) begin
            next_lnk.checking = 1'b0;
        end else if (startTest) begin
            next_lnk.checking = 1'b1;
            next_lnk.passHeld = 1'b1;
            next_lnk.fwdCnt   = STC_CNT_RESET;
        end

        // payload must be all zeros in bits 0..34
        frameErr = lnk.checking && linkLock && linkFrameValid
                   && (|linkPayload);
        if (frameErr) begin
            next_lnk.errPulse = 1'b1;
            next_lnk.passHeld = 1'b0;
            next_lnk.fwdCnt   = stc_sat_inc(lnk.fwdCnt);
        end

        // back-channel CRC errors, only after link detect
        if (remoteRise) begin
            next_lnk.bcCnt = STC_CNT_RESET;
            next_lnk.tcCnt = STC_CNT_RESET;
        end else if (bcLinkDetect && bcCrcError) begin
            next_lnk.bcCnt = stc_sat_inc(lnk.bcCnt);
        end

        // software clear of the test count
        if (swClear && !remoteRise) begin
            next_lnk.tcCnt = STC_CNT_RESET;
        end

        // software clear applies first in the same cycle, then the increment, leaving a count of one
        if (!remoteRise && bcLinkDetect && bcCrcError && remoteInTest) begin
            next_lnk.tcCnt = stc_sat_inc(swClear ? STC_CNT_RESET : lnk.tcCnt);
        end
        next_lnk.gray[0] = stc_to_gray(next_lnk.fwdCnt);
        next_lnk.gray[1] = stc_to_gray(next_lnk.bcCnt);
        next_lnk.gray[2] = stc_to_gray(next_lnk.tcCnt);

        // clock enable low holds every link flop but its own synchroniser
        if (!lnk.ceS2) begin
            next_lnk      = lnk;
            next_lnk.ceS1 = clockEnable;
            next_lnk.ceS2 = lnk.ceS1;
        end
    end

    // link domain register; clock enable acts through the
    // synchronised copy held in the next-state logic
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            lnk <= LINK_RESET;
        end else begin
            lnk <= next_lnk;
        end
    end

    // falling-edge copy of the error pulse, ends it half a period in;
    // only the result pin reads it
    always_ff @(negedge linkClk or posedge rst) begin
        if (rst) begin
            errNeg <= 1'b0;
        end else begin
            errNeg <= lnk.errPulse;
        end
    end

    // register read data, straight from its flop
    assign regRdata        = sys.rdata;

    // back-channel request, oscillator choice and lock level
    assign selfTestRequest = sys.testReq;
    assign oscSelect       = sys.oscSel;
    assign lockStatus      = sys.lockOut;

    // result pin: low for the high half of linkClk after an errored frame;
    // a gate of four link flops, errPulse and errNeg on opposite edges for the half-period pulse
    assign passPin = lnk.checking ? !(lnk.errPulse && !errNeg)
                                  : lnk.passHeld;
endmodule : stc_checker

// ### testbench/stc_chk.sv
/* stc_chk: port assertions for the self-test checker.
   assumes clockEnable is held high and bound with bind below. */
`timescale 1ns/1ps
module stc_chk
    import stc_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       selfTestEnablePin,
    input wire logic       selfTestClockSelectPin,
    input wire logic       powerDownBarPin,
    input wire logic       linkLock,
    input wire logic       bcLinkDetect,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regRdata,
    input wire logic       selfTestRequest,
    input wire logic       oscSelect,
    input wire logic       lockStatus,
    input wire logic       passPin
);
    // one domain for every check
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    a_test_request: assert property ($rose(selfTestEnablePin) |-> ##[1:5] selfTestRequest)
        else $error("self-test request late");
    a_osc_follow: assert property ($rose(selfTestClockSelectPin) |-> ##[1:5] oscSelect)
        else $error("oscillator select late");
    a_lock_valid: assert property ($rose(linkLock) |-> ##[1:6] lockStatus)
        else $error("lock status late");
    a_pass_start: assert property ($rose(selfTestRequest) |-> ##[1:40] passPin)
        else $error("result not high at start");
    a_result_held: assert property (!selfTestRequest [*8] |=> $stable(passPin))
        else $error("held result moved");
    a_pdb_clear: assert property ((!powerDownBarPin && !selfTestClockSelectPin) [*6] |-> !oscSelect)
        else $error("config not cleared");
    a_unmapped_zero: assert property ((regAddr == 8'h00) [*2] |-> regRdata == 8'h00)
        else $error("unmapped read nonzero");
    a_link_detect: assert property ((regAddr == STC_ADDR_LINK_DETECT && bcLinkDetect) [*6]
        |-> regRdata[STC_LD_BIT])
        else $error("link detect bit low");
endmodule : stc_chk

bind stc_checker stc_chk u_chk (.clock, .rst, .selfTestEnablePin, .selfTestClockSelectPin,
    .powerDownBarPin, .linkLock, .bcLinkDetect, .regAddr, .regRdata, .selfTestRequest,
    .oscSelect, .lockStatus, .passPin);

// ### testbench/stc_serializer_model.sv
/* stc_serializer_model: remote serializer on the link clock.
   assumes toggle requests from the bench held for several link cycles. */
`timescale 1ns/1ps
module stc_serializer_model (
    input  wire logic        linkClk,
    input  wire logic        rst,
    input  wire logic        selfTestRequest,
    input  wire logic        errToggle,
    input  wire logic        errBurst,
    input  wire logic        crcToggle,
    output logic [34:0]      linkPayload,
    output logic             linkFrameValid,
    output logic             linkLock,
    output logic             remoteInTest,
    output logic             bcLinkDetect,
    output logic             bcCrcError
);
    logic [2:0] reqS, errS, crcS, brsS;
    logic [5:0] pos;
    logic [1:0] phase;
    logic       pend;
    // frame every fourth link cycle, errors one bit at a time
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            {reqS, errS, crcS, brsS, pos, phase, pend} <= '0;
            {linkFrameValid, linkLock, remoteInTest, bcLinkDetect, bcCrcError} <= '0;
            linkPayload <= '0;
        end else begin
            reqS <= {reqS[1:0], selfTestRequest};
            errS <= {errS[1:0], errToggle};
            crcS <= {crcS[1:0], crcToggle};
            brsS <= {brsS[1:0], errBurst};
            remoteInTest <= reqS[1]; // wakes on request
            linkLock <= 1'b1;
            bcLinkDetect <= linkLock;
            bcCrcError <= crcS[2] ^ crcS[1];
            phase <= phase + 2'h1;
            linkFrameValid <= (phase == 2'h3);
            if (phase == 2'h3) begin
                linkPayload <= (pend || brsS[1]) ? 35'h1 << pos : 35'h0; // one bit set on a pending or burst error, else zeros
                pend <= 1'b0;
                pos <= (pos == 6'h22) ? 6'h00 : pos + 6'h01;
            end else begin
                linkPayload <= ~linkPayload; // no stale value between frames
            end
            if (errS[2] ^ errS[1]) begin
                pend <= 1'b1;
            end
        end
    end
endmodule : stc_serializer_model

// ### testbench/test_serial_link_self_test_checker.sv
/* test_serial_link_self_test_checker: self-checking bench.
   assumes the serializer model and the bound checker. */
`timescale 1ns/1ps
module test_serial_link_self_test_checker;
    import stc_pkg::*;
    logic clock, linkClk, rst, clockEnable, selfTestEnablePin, selfTestClockSelectPin;
    logic powerDownBarPin, linkFrameValid, linkLock, remoteInTest, bcLinkDetect, bcCrcError;
    logic [34:0] linkPayload;
    logic [7:0]  regAddr, regWdata, regRdata;
    logic regWrite, selfTestRequest, oscSelect, lockStatus, passPin;
    logic errToggle, errBurst, crcToggle;
    int fail_count = 0, total_checks = 0, lows = 0, seed = 27, n, lows0;
    stc_checker DUT (.*);
    stc_serializer_model u_ser (.*);
    // clocks, unrelated in phase
    initial begin
        clock = 0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        linkClk = 0;
        #3.7;
        forever #7.5 linkClk = ~linkClk;
    end
    always @(negedge passPin) lows++;
    function automatic logic [7:0] sat(int c);
        return (c > 255) ? 8'hFF : c[7:0];
    endfunction : sat
    task automatic tick(int c);
        repeat (c) @(posedge clock);
        #2;
    endtask : tick
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        regAddr = a;
        regWdata = d;
        regWrite = 1;
        tick(1);
        regWrite = 0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
        regAddr = a;
        tick(2);
        chk(nm, e, regRdata);
    endtask : rd
    task automatic waitReq(logic v);
        for (int i = 0; i < 50 && selfTestRequest !== v; i++) tick(1);
        if (selfTestRequest !== v) begin
            fail_count++;
            conclude();
        end
    endtask : waitReq
    // main sequence
    initial begin
        {rst, clockEnable, powerDownBarPin} = 3'h7;
        {selfTestEnablePin, selfTestClockSelectPin, regWrite, errToggle, errBurst, crcToggle} = '0;
        {regAddr, regWdata} = 16'h0000;
        tick(12);
        rst = 0;
        tick(2);
        chk("pass", 8'h01, {7'h00, passPin});
        rd(STC_ADDR_CFG, STC_CFG_RESET, "cfg");
        rd(8'h00, 8'h00, "unmapped");
        rd(STC_ADDR_LINK_DETECT, 8'h01, "link detect");
        tick(6);
        wr(STC_ADDR_FWD_ERR, 8'h5A);
        rd(STC_ADDR_FWD_ERR, 8'h00, "fwd ro");
        for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? 0 : (k == 1) ? 1 + ($unsigned($random(seed)) % 6) : 300;
            if (k == 2) wr(STC_ADDR_CFG, 8'h01);
            else selfTestEnablePin = 1;
            waitReq(1);
            tick(10);
            chk("start", 8'h01, {7'h00, passPin});
            chk("lock", 8'h01, {7'h00, lockStatus});
            rd(STC_ADDR_BC_CRC, 8'h00, "bc clear");
            lows0 = lows;
            if (k < 2) repeat (n) begin
                errToggle = ~errToggle;
                tick(6);
            end else begin
                errBurst = 1;
                tick(800);
                errBurst = 0;
            end
            repeat (k + 1) begin
                crcToggle = ~crcToggle;
                tick(4);
            end
            tick(6);
            if (k < 2) chk("pulses", 8'(n), 8'(lows - lows0));
            rd(STC_ADDR_FWD_ERR, sat(n), "fwd");
            rd(STC_ADDR_BC_CRC, 8'(k + 1), "bc crc");
            if (k == 2) wr(STC_ADDR_CFG, 8'h00);
            else selfTestEnablePin = 0;
            waitReq(0);
            tick(10);
            chk("held", 8'(n == 0), {7'h00, passPin});
            tick(40);
            chk("kept", 8'(n == 0), {7'h00, passPin});
            rd(STC_ADDR_TEST_CRC, 8'(k + 1), "test crc");
            $display("run %0d done", k);
        end
        selfTestClockSelectPin = 1;
        tick(6);
        chk("osc pin", 8'h01, {7'h00, oscSelect});
        selfTestClockSelectPin = 0;
        wr(STC_ADDR_CFG, 8'h02);
        tick(3);
        chk("osc reg", 8'h01, {7'h00, oscSelect});
        powerDownBarPin = 0;
        tick(STC_PDB_MIN_CYC);
        chk("osc pdb", 8'h00, {7'h00, oscSelect});
        powerDownBarPin = 1;
        rd(STC_ADDR_CFG, 8'h00, "cfg pdb");
        $display("power down done");
        conclude();
    end
endmodule : test_serial_link_self_test_checker
